// ### verilog/anpd_pkg.sv
// Constants and types shared by the negotiation and parallel detection monitor.
`default_nettype none
package anpd_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLK_KHZ         = 25000;
  // Longest time allowed for a whole negotiation, in milliseconds.
  localparam int NEG_LIMIT_MS    = 500;
  localparam int NEG_LIMIT_CYC   = NEG_LIMIT_MS * CLK_KHZ;
  // Time spent sending bursts before parallel detection is tried.
  localparam int LISTEN_MS       = 50;
  localparam int LISTEN_CYC      = LISTEN_MS * CLK_KHZ;
  localparam int TMR_W           = 24;

  // ==========================================================================
  // Ability word bit positions, shared by the local and partner words
  localparam int AB_HD10         = 5;
  localparam int AB_FD10         = 6;
  localparam int AB_HD100        = 7;
  localparam int AB_FD100        = 8;
  localparam int AB_T4           = 9;
  localparam int AB_RFAULT       = 13;

  // ==========================================================================
  // Technology enable positions
  localparam int TECH_HD10       = 0;
  localparam int TECH_FD10       = 1;
  localparam int TECH_HD100      = 2;
  localparam int TECH_FD100      = 3;
  localparam logic [3:0] TECH_NONE = 4'h0;

  // ==========================================================================
  // Progress monitor codes, ordered so that larger means further along
  localparam logic [1:0] PRG_IDLE   = 2'h0;
  localparam logic [1:0] PRG_LISTEN = 2'h1;
  localparam logic [1:0] PRG_DETECT = 2'h2;
  localparam logic [1:0] PRG_DONE   = 2'h3;
  localparam logic [1:0] PRG_RESET  = 2'h0;

  // ==========================================================================
  // Arbitration states
  typedef enum logic [1:0] {
    ANPD_IDLE   = 2'b00,
    ANPD_LISTEN = 2'b01,
    ANPD_PDET   = 2'b10,
    ANPD_DONE   = 2'b11
  } anpd_state_type;
endpackage
`default_nettype wire

// ### verilog/anpd_monitor.sv
// Negotiation arbitration with parallel detection, remote fault and progress monitor.
`timescale 1ns/1ns
`default_nettype none
module anpd_monitor #(
  parameter int LISTEN_CYC    = anpd_pkg::LISTEN_CYC,
  parameter int NEG_LIMIT_CYC = anpd_pkg::NEG_LIMIT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        an_enable,
  input  wire logic        restart_wr,
  input  wire logic        status_rd,
  input  wire logic [15:0] adv_word,
  input  wire logic        local_fault,
  input  wire logic        link_ok,
  input  wire logic        rx_word_valid,
  input  wire logic [15:0] rx_word,
  input  wire logic        rx_nlp,
  input  wire logic        rx_idle100,
  input  wire logic        rx_energy,
  output logic             restart_bit,
  output logic             flp_tx_en,
  output logic [15:0]      tx_word,
  output logic [15:0]      lp_ability,
  output logic             partner_negotiation_capable,
  output logic             pd_fault,
  output logic             no_signal,
  output logic             remote_fault,
  output logic             an_complete,
  output logic [3:0]       tech_en,
  output logic [1:0]       progress
);

  // ==========================================================================
  // Parameter checks, refused at elaboration.
  if (LISTEN_CYC < 1 || LISTEN_CYC >= NEG_LIMIT_CYC) begin : g_bad_listen
    $error("listen time must be at least one cycle and below the limit");
  end
  if (NEG_LIMIT_CYC >= (1 << anpd_pkg::TMR_W)) begin : g_bad_limit
    $error("negotiation limit does not fit the timer");
  end

  localparam logic [anpd_pkg::TMR_W-1:0] LISTEN_END = anpd_pkg::TMR_W'(LISTEN_CYC - 1);
  localparam logic [anpd_pkg::TMR_W-1:0] LIMIT_END  = anpd_pkg::TMR_W'(NEG_LIMIT_CYC - 1);

  // ==========================================================================
  // State
  typedef struct packed {
    anpd_pkg::anpd_state_type   st;
    logic                       restart;
    logic                       en_d;
    logic [anpd_pkg::TMR_W-1:0] lcnt;
    logic [anpd_pkg::TMR_W-1:0] tcnt;
    logic                       nlp_s;
    logic                       idle_s;
    logic                       sig_s;
    logic [15:0]                lp_ab;
    logic                       lp_cap;
    logic                       pd_flt;
    logic                       no_sig;
    logic                       done;
    logic [3:0]                 tech;
    logic [1:0]                 prog;
    logic [15:0]                txw;
  } anpd_regs_type;

  anpd_regs_type s_r;
  anpd_regs_type s_nxt;
  logic          rst_ev;
  logic [15:0]   common;
  logic [1:0]    cur_prog;

  // Arbitration is restarted by a restart write, a rising enable after a
  // drop, or the link going away after completion.
  assign rst_ev = s_r.restart | (an_enable & ~s_r.en_d)
                | ((s_r.st == anpd_pkg::ANPD_DONE) & ~link_ok);
  assign common = adv_word & rx_word;

  // Progress code of the current arbitration state.
  always_comb begin
    case (s_r.st)
      anpd_pkg::ANPD_LISTEN: cur_prog = anpd_pkg::PRG_LISTEN;
      anpd_pkg::ANPD_PDET:   cur_prog = anpd_pkg::PRG_DETECT;
      anpd_pkg::ANPD_DONE:   cur_prog = anpd_pkg::PRG_DONE;
      default:               cur_prog = anpd_pkg::PRG_IDLE;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt         = s_r;
    s_nxt.restart = restart_wr;
    s_nxt.en_d    = an_enable;
    // The advertised remote fault is also set by the local link fault.
    s_nxt.txw = adv_word;
    s_nxt.txw[anpd_pkg::AB_RFAULT] = adv_word[anpd_pkg::AB_RFAULT] | local_fault;

    if (s_r.st != anpd_pkg::ANPD_IDLE && s_r.st != anpd_pkg::ANPD_DONE) begin
      s_nxt.tcnt = s_r.tcnt + 1'b1;
    end

    if (!an_enable || rst_ev) begin
      // Restart returns the machine to idle; completion and technology are dropped, progress kept.
      s_nxt.st     = anpd_pkg::ANPD_IDLE;
      s_nxt.lcnt   = '0;
      s_nxt.tcnt   = '0;
      s_nxt.nlp_s  = 1'b0;
      s_nxt.idle_s = 1'b0;
      s_nxt.sig_s  = 1'b0;
      s_nxt.done   = 1'b0;
      s_nxt.tech   = anpd_pkg::TECH_NONE;
    end else begin
      case (s_r.st)
        anpd_pkg::ANPD_IDLE: begin
          s_nxt.st     = anpd_pkg::ANPD_LISTEN;
          s_nxt.lp_ab  = '0;
          s_nxt.lp_cap = 1'b0;
          s_nxt.pd_flt = 1'b0;
          s_nxt.no_sig = 1'b0;
        end
        anpd_pkg::ANPD_LISTEN: begin
          s_nxt.lcnt   = s_r.lcnt + 1'b1;
          s_nxt.nlp_s  = s_r.nlp_s | rx_nlp;
          s_nxt.idle_s = s_r.idle_s | rx_idle100;
          s_nxt.sig_s  = s_r.sig_s | rx_energy;
          if (rx_word_valid) begin
            s_nxt.lp_ab  = rx_word;
            s_nxt.lp_cap = 1'b1;
            s_nxt.done   = 1'b1;
            s_nxt.st     = anpd_pkg::ANPD_DONE;
            // Fixed priority over the common abilities; 100 Mb/s T4 enables nothing.
            if (common[anpd_pkg::AB_FD100]) begin
              s_nxt.tech = 4'h1 << anpd_pkg::TECH_FD100;
            end else if (common[anpd_pkg::AB_T4]) begin
              s_nxt.tech = anpd_pkg::TECH_NONE;
            end else if (common[anpd_pkg::AB_HD100]) begin
              s_nxt.tech = 4'h1 << anpd_pkg::TECH_HD100;
            end else if (common[anpd_pkg::AB_FD10]) begin
              s_nxt.tech = 4'h1 << anpd_pkg::TECH_FD10;
            end else if (common[anpd_pkg::AB_HD10]) begin
              s_nxt.tech = 4'h1 << anpd_pkg::TECH_HD10;
            end else begin
              s_nxt.tech = anpd_pkg::TECH_NONE;
            end
          end else if (s_r.lcnt == LISTEN_END) begin
            s_nxt.st = anpd_pkg::ANPD_PDET;
          end
        end
        anpd_pkg::ANPD_PDET: begin
          s_nxt.lcnt = '0;
          if (s_r.nlp_s && s_r.idle_s) begin
            s_nxt.pd_flt = 1'b1;
            s_nxt.tech   = anpd_pkg::TECH_NONE;
            s_nxt.st     = anpd_pkg::ANPD_LISTEN;
          end else if (s_r.nlp_s || s_r.idle_s) begin
            s_nxt.lp_cap = 1'b0;
            s_nxt.pd_flt = 1'b0;
            s_nxt.no_sig = 1'b0;
            s_nxt.done   = 1'b1;
            s_nxt.st     = anpd_pkg::ANPD_DONE;
            if (s_r.nlp_s) begin
              s_nxt.lp_ab[anpd_pkg::AB_HD10] = 1'b1;
              s_nxt.tech = 4'h1 << anpd_pkg::TECH_HD10;
            end else begin
              s_nxt.lp_ab[anpd_pkg::AB_HD100] = 1'b1;
              s_nxt.tech = 4'h1 << anpd_pkg::TECH_HD100;
            end
          end else begin
            s_nxt.no_sig = ~s_r.sig_s;
            s_nxt.st     = anpd_pkg::ANPD_LISTEN;
          end
          s_nxt.nlp_s  = 1'b0;
          s_nxt.idle_s = 1'b0;
          s_nxt.sig_s  = 1'b0;
        end
        anpd_pkg::ANPD_DONE: begin
          s_nxt.st = anpd_pkg::ANPD_DONE;
        end
        default: begin
          s_nxt.st = anpd_pkg::ANPD_IDLE;
        end
      endcase
      // A negotiation that overruns its limit starts over from idle.  The timer
      // wraps here too, so a completion on the last cycle cannot leave it past the limit.
      if (s_r.tcnt == LIMIT_END) begin
        s_nxt.tcnt = '0;
        if (s_nxt.st != anpd_pkg::ANPD_DONE) begin
          s_nxt.st   = anpd_pkg::ANPD_IDLE;
          s_nxt.lcnt = '0;
        end
      end
    end

    // A read reloads the progress bits; otherwise they only rise, and
    // never after reaching completion.
    if (status_rd) begin
      s_nxt.prog = cur_prog;
    end else if (s_r.prog != anpd_pkg::PRG_DONE && cur_prog > s_r.prog) begin
      s_nxt.prog = cur_prog;
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_r        <= '0;
      s_r.st     <= anpd_pkg::ANPD_IDLE;
      s_r.prog   <= anpd_pkg::PRG_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign restart_bit                 = s_r.restart;
  assign flp_tx_en                   = (s_r.st == anpd_pkg::ANPD_LISTEN);
  assign tx_word                     = s_r.txw;
  assign lp_ability                  = s_r.lp_ab;
  assign partner_negotiation_capable = s_r.lp_cap;
  assign pd_fault                    = s_r.pd_flt;
  assign no_signal                   = s_r.no_sig;
  assign remote_fault                = s_r.lp_ab[anpd_pkg::AB_RFAULT];
  assign an_complete                 = s_r.done;
  assign tech_en                     = s_r.tech;
  assign progress                    = s_r.prog;

  // ==========================================================================
  // Assertions
  restart_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    restart_bit && !restart_wr |=> !restart_bit)
    else $error("restart bit did not clear itself");

  restart_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    restart_bit |=> s_r.st == anpd_pkg::ANPD_IDLE && !an_complete)
    else $error("restart did not return arbitration to idle");

  start_listen_a: assert property (@(posedge core_clk) disable iff (reset)
    s_r.st == anpd_pkg::ANPD_IDLE && an_enable && !rst_ev |=> flp_tx_en)
    else $error("enabled negotiation did not start");

  pd_legacy10_a: assert property (@(posedge core_clk) disable iff (reset)
    s_r.st == anpd_pkg::ANPD_PDET && s_r.nlp_s && !s_r.idle_s && an_enable && !rst_ev
    |=> an_complete && !partner_negotiation_capable && lp_ability[anpd_pkg::AB_HD10]
        && tech_en == 4'h1)
    else $error("10 Mb/s parallel detection result wrong");

  pd_legacy100_a: assert property (@(posedge core_clk) disable iff (reset)
    s_r.st == anpd_pkg::ANPD_PDET && !s_r.nlp_s && s_r.idle_s && an_enable && !rst_ev
    |=> an_complete && !partner_negotiation_capable && lp_ability[anpd_pkg::AB_HD100]
        && tech_en == 4'h4)
    else $error("100 Mb/s parallel detection result wrong");

  pd_fault_a: assert property (@(posedge core_clk) disable iff (reset)
    s_r.st == anpd_pkg::ANPD_PDET && s_r.nlp_s && s_r.idle_s && an_enable && !rst_ev
    |=> pd_fault && tech_en == 4'h0 && !an_complete)
    else $error("multiple technologies did not raise the fault");

  no_signal_a: assert property (@(posedge core_clk) disable iff (reset)
    s_r.st == anpd_pkg::ANPD_PDET && !s_r.nlp_s && !s_r.idle_s && !s_r.sig_s
      && an_enable && !rst_ev |=> no_signal)
    else $error("absent signal not reported");

  flp_reply_a: assert property (@(posedge core_clk) disable iff (reset)
    flp_tx_en && rx_word_valid && an_enable && !rst_ev
    |=> partner_negotiation_capable && an_complete
        && remote_fault == $past(rx_word[anpd_pkg::AB_RFAULT]))
    else $error("burst reply not recorded");

  adv_fault_a: assert property (@(posedge core_clk) disable iff (reset)
    local_fault |=> tx_word[anpd_pkg::AB_RFAULT])
    else $error("local fault not advertised");

  prog_rise_a: assert property (@(posedge core_clk) disable iff (reset)
    !status_rd |=> progress >= $past(progress))
    else $error("progress bits fell without a read");

  prog_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    progress == anpd_pkg::PRG_DONE && !status_rd |=> progress == anpd_pkg::PRG_DONE)
    else $error("progress changed after completion");

  limit_bound_a: assert property (@(posedge core_clk) disable iff (reset)
    s_r.tcnt <= LIMIT_END)
    else $error("negotiation timer overran its limit");

  // Reset, disable and result checks; every output here is registered, so
  // each implication looks one cycle after its cause; tech_single_a is checked in every cycle.
  reset_idle_a: assert property (@(posedge core_clk)
    reset |=> s_r.st == anpd_pkg::ANPD_IDLE && progress == anpd_pkg::PRG_RESET && !an_complete)
    else $error("reset did not clear arbitration and progress");

  tech_single_a: assert property (@(posedge core_clk) disable iff (reset)
    $onehot0(tech_en))
    else $error("more than one technology enabled");

  disable_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    !an_enable |=> !flp_tx_en && !an_complete && tech_en == anpd_pkg::TECH_NONE)
    else $error("disabled negotiation left results active");

  burst_word_a: assert property (@(posedge core_clk) disable iff (reset)
    !local_fault |=> tx_word == $past(adv_word))
    else $error("burst word does not follow the advertisement");

  done_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    an_complete && an_enable && link_ok && !restart_bit |=> an_complete)
    else $error("completion dropped without a restart");

  remote_fault_a: assert property (@(posedge core_clk) disable iff (reset)
    flp_tx_en && rx_word_valid && rx_word[anpd_pkg::AB_RFAULT] && an_enable && !rst_ev |=> remote_fault)
    else $error("partner fault not reported");

  top_tech_a: assert property (@(posedge core_clk) disable iff (reset)
    flp_tx_en && rx_word_valid && common[anpd_pkg::AB_FD100] && an_enable && !rst_ev
    |=> tech_en[anpd_pkg::TECH_FD100])
    else $error("common full duplex 100 Mb/s not chosen");

endmodule
`default_nettype wire

// ### tb/anpd_remote_phy.sv
// Behavioural model of the remote PHY at the far end of the cable.
`timescale 1ns/1ns
`default_nettype none
module anpd_remote_phy (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        flp_tx_en,
  input  wire logic [2:0]  mode,
  input  wire logic [7:0]  dly,
  input  wire logic [15:0] word,
  output logic             rx_word_valid,
  output logic [15:0]      rx_word,
  output logic             rx_nlp,
  output logic             rx_idle100,
  output logic             rx_energy
);
  // ==========================================================================
  // Reply modes: 0 silent, 1 bursts, 2 link pulses, 3 idles, 4 pulses and idles.
  logic [7:0] cnt_r;
  logic       sent_r;

  // One burst word per listening period, after a programmable delay.
  always_ff @(posedge core_clk) begin
    if (reset || !flp_tx_en) begin
      cnt_r         <= 8'h00;
      sent_r        <= 1'b0;
      rx_word_valid <= 1'b0;
    end else begin
      rx_word_valid <= 1'b0;
      if (mode == 3'h1 && !sent_r) begin
        if (cnt_r == dly) begin
          rx_word_valid <= 1'b1;
          sent_r        <= 1'b1;
        end
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  // Outside the valid pulse the word is not held, so show its inverse.
  assign rx_word    = rx_word_valid ? word : ~word;
  assign rx_nlp     = (mode == 3'h2) || (mode == 3'h4);
  assign rx_idle100 = (mode == 3'h3) || (mode == 3'h4);
  assign rx_energy  = (mode != 3'h0);
endmodule
`default_nettype wire

// ### tb/test_anpd_monitor.sv
// Self-checking bench for the negotiation and parallel detection monitor.
`timescale 1ns/1ns
`default_nettype none
module test_anpd_monitor;
  logic        core_clk, reset, an_enable, restart_wr, status_rd, local_fault, link_ok;
  logic [15:0] adv_word, word, rx_word, tx_word, lp_ability;
  logic [2:0]  mode;
  logic [7:0]  dly;
  logic        rx_word_valid, rx_nlp, rx_idle100, rx_energy, restart_bit, flp_tx_en;
  logic        cap, pd_fault, no_signal, remote_fault, an_complete;
  logic [3:0]  tech_en;
  logic [1:0]  progress, prg;
  int          n_fail, num_checks, i;

  anpd_monitor #(.LISTEN_CYC(20), .NEG_LIMIT_CYC(200)) u_anpd_monitor (
    .core_clk(core_clk), .reset(reset), .an_enable(an_enable), .restart_wr(restart_wr),
    .status_rd(status_rd), .adv_word(adv_word), .local_fault(local_fault), .link_ok(link_ok),
    .rx_word_valid(rx_word_valid), .rx_word(rx_word), .rx_nlp(rx_nlp), .rx_idle100(rx_idle100),
    .rx_energy(rx_energy), .restart_bit(restart_bit), .flp_tx_en(flp_tx_en), .tx_word(tx_word),
    .lp_ability(lp_ability), .partner_negotiation_capable(cap), .pd_fault(pd_fault),
    .no_signal(no_signal), .remote_fault(remote_fault), .an_complete(an_complete),
    .tech_en(tech_en), .progress(progress));

  anpd_remote_phy u_anpd_remote_phy (
    .core_clk(core_clk), .reset(reset), .flp_tx_en(flp_tx_en), .mode(mode), .dly(dly),
    .word(word), .rx_word_valid(rx_word_valid), .rx_word(rx_word), .rx_nlp(rx_nlp),
    .rx_idle100(rx_idle100), .rx_energy(rx_energy));

  // ==========================================================================
  // Helpers
  function automatic logic [3:0] best_tech(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] c;
    c = a & b;
    if (c[anpd_pkg::AB_FD100]) return 4'h8;
    if (c[anpd_pkg::AB_T4]) return 4'h0;
    if (c[anpd_pkg::AB_HD100]) return 4'h4;
    if (c[anpd_pkg::AB_FD10]) return 4'h2;
    if (c[anpd_pkg::AB_HD10]) return 4'h1;
    return 4'h0;
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Waits for 0 complete, 1 parallel fault, 2 no signal, 3 bursts sent.
  task automatic wait_for(input int sel, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(posedge core_clk);
      #1;
      if ((sel == 0 && an_complete === 1'b1) || (sel == 1 && pd_fault === 1'b1) ||
          (sel == 2 && no_signal === 1'b1) || (sel == 3 && flp_tx_en === 1'b1)) return;
    end
    n_fail++;
    $display("Error wait %0d timed out", sel);
    conclude();
  endtask

  // Restart through the control bit; only used once negotiation has completed.
  task automatic restart_neg();
    @(posedge core_clk) restart_wr <= 1'b1;
    #1 prg = progress;
    @(posedge core_clk) restart_wr <= 1'b0;
    #1 check("restart_bit", restart_bit, 1'b1);
    @(posedge core_clk);
    #1 check("restart_clear", restart_bit, 1'b0);
    check("progress_kept", progress, prg);
    wait_for(3, 10);
    check("complete_clr", an_complete, 1'b0);
    check("tech_clr", tech_en, 4'h0);
    check("no_sig_clr", no_signal, 1'b0);
  endtask

  // ==========================================================================
  // Stimulus
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    n_fail = 0;
    num_checks = 0;
    reset <= 1'b1; an_enable <= 1'b1; restart_wr <= 1'b0; status_rd <= 1'b0;
    local_fault <= 1'b0; link_ok <= 1'b1; adv_word <= 16'h03e0; word <= 16'h0000;
    mode <= 3'h0; dly <= 8'h00;
    void'($urandom(93867));
    repeat (11) @(posedge core_clk);
    #1 check("tech_rst", tech_en, 4'h0);
    check("progress_rst", progress, anpd_pkg::PRG_RESET);
    check("complete_rst", an_complete, 1'b0);
    @(posedge core_clk) reset <= 1'b0;
    wait_for(2, 100);
    check("pd_fault_quiet", pd_fault, 1'b0);
    @(posedge core_clk) local_fault <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 check("tx_fault", tx_word, adv_word | 16'h2000);
    @(posedge core_clk) local_fault <= 1'b0;
    @(posedge core_clk) mode <= 3'h1;
    wait_for(0, 100);
    for (i = 0; i < 6; i++) begin
      @(posedge core_clk);
      word <= (i == 0) ? 16'h2200 : 16'($urandom);
      adv_word <= (i == 0) ? 16'h03e0 : 16'($urandom);
      dly <= 8'($urandom_range(15, 0));
      restart_neg();
      wait_for(0, 60);
      check("lp_ability", lp_ability, word);
      check("cap_flp", cap, 1'b1);
      check("tech_flp", tech_en, best_tech(adv_word, word));
      check("rfault", remote_fault, word[13]);
      check("progress_done", progress, anpd_pkg::PRG_DONE);
      check("tx_word", tx_word, adv_word);
    end
    @(posedge core_clk) status_rd <= 1'b1;
    @(posedge core_clk) status_rd <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1 check("progress_read", progress, anpd_pkg::PRG_DONE);
    for (i = 2; i <= 3; i++) begin
      @(posedge core_clk) mode <= 3'(i);
      restart_neg();
      @(posedge core_clk) status_rd <= 1'b1;
      @(posedge core_clk) status_rd <= 1'b0;
      #1 check("progress_rd", progress, anpd_pkg::PRG_LISTEN);
      wait_for(0, 150);
      check("cap_pd", cap, 1'b0);
      check("lp_pd", lp_ability, (i == 2) ? 16'h0020 : 16'h0080);
      check("tech_pd", tech_en, (i == 2) ? 4'h1 : 4'h4);
      @(posedge core_clk);
      #1 check("progress_pd", progress, anpd_pkg::PRG_DONE);
    end
    @(posedge core_clk) mode <= 3'h4;
    restart_neg();
    wait_for(1, 150);
    check("tech_fault", tech_en, 4'h0);
    check("complete_fault", an_complete, 1'b0);
    @(posedge core_clk) mode <= 3'h1;
    wait_for(0, 200);
    @(posedge core_clk) an_enable <= 1'b0;
    repeat (3) @(posedge core_clk);
    an_enable <= 1'b1;
    wait_for(3, 10);
    check("complete_toggle", an_complete, 1'b0);
    wait_for(0, 60);
    @(posedge core_clk) link_ok <= 1'b0;
    @(posedge core_clk) link_ok <= 1'b1;
    wait_for(3, 10);
    check("complete_linkfail", an_complete, 1'b0);
    wait_for(0, 60);
    check("tech_relink", tech_en, best_tech(adv_word, word));
    @(posedge core_clk) reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 check("progress_rst2", progress, anpd_pkg::PRG_RESET);
    check("complete_rst2", an_complete, 1'b0);
    check("cap_rst2", cap, 1'b0);
    @(posedge core_clk) reset <= 1'b0;
    wait_for(3, 10);
    conclude();
  end
endmodule
`default_nettype wire
